/* File: logic/pcr_config_header.sv */
`timescale 1ns/100ps
// Summary of operation
// [R1] A read-only 8-bit header layout code sits in the self-test dword.
// [R2] The self-test byte always reads zero and ignores writes.
// [R3] Window base bits 31 to 4 take a write only where the window mask allows.
// [R4] Window base bit 3 reads that window's prefetch enable input, not its mask.
// [R5] Window base bits 2 to 1 always read zero for 32-bit decode only.
// [R6] Window base bit 0 always reads zero since windows are memory space.
// [R7] A read-only 16-bit board device ident is returned to reads.
// [R8] A read-only 16-bit board maker ident is returned to reads.
// [R9] The capability list pointer is read-only and reads 40h.
// [R10] The irq routing line is written by the host, reset to zero and read back.
// [R11] The irq pin byte is fixed at 01h.
// [R12] The burst length hint is writable and resets to zero.
// [R13] The access interval hint is writable and resets to zero.
// [R14] The local processor reaches every header register through mirror offsets.
// [R15] The host reaches the mirror registers only through memory window 0.
// [R16] Mirror registers of the bus clock domain are only served while that clock runs.
// [R17] Window address bits that the mask makes read-only read as zero.
module pcr_config_header
  import pcr_pkg::*;
#(
  parameter logic [7:0]  HDR_LAYOUT     = 8'h00,    // Header layout code.
  parameter logic [15:0] BOARD_DEV_ID   = 16'h0000, // Arbitrary value.
  parameter logic [15:0] BOARD_MAKER_ID = 16'h0000  // Arbitrary value.
) (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire pcr_pkg::pcr_req_t   cfg_req_i,
  input  wire pcr_pkg::pcr_req_t   loc_req_i,
  input  wire pcr_pkg::pcr_req_t   mem_req_i,
  input  wire logic [31:0]         win_mask_i [pcr_pkg::NUM_WIN],
  input  wire logic [5:0]          win_prefetch_i,
  input  wire logic                bus_clk_running_i,
  output logic [31:0]              cfg_rdata_o,
  output logic                     cfg_ack_o,
  output logic [31:0]              loc_rdata_o,
  output logic                     loc_ack_o,
  output logic [31:0]              mem_rdata_o,
  output logic                     mem_ack_o
);
  import pcr_pkg::*;

  // ==========================================================================
  // Helpers

  // Expands byte enables into a bit mask.
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // Maps a mirror byte offset onto a header dword index; bit 6 flags a hit.
  function automatic logic [6:0] mirror_index(input logic [11:0] off);
    logic hit;
    hit = (off == MIR_HDR) || (off == MIR_BOARD) || (off == MIR_CAP) || (off == MIR_IRQ);
    if (off >= MIR_WIN0 && off <= MIR_WIN5 && off[1:0] == 2'h0) begin
      mirror_index = {1'b1, IDX_WIN0 + 6'((off - MIR_WIN0) >> 2)};
    end else if (hit) begin
      mirror_index = {1'b1, 6'((off - MIR_CFG_BASE) >> 2)};
    end else begin
      mirror_index = 7'h00;
    end
  endfunction : mirror_index

  // ==========================================================================
  // Register state

  logic [31:WIN_ADDR_LSB] win_q [NUM_WIN];
  logic [31:WIN_ADDR_LSB] win_d [NUM_WIN];
  logic [7:0]             line_q, line_d;
  logic [7:0]             burst_q, burst_d;
  logic [7:0]             intv_q, intv_d;
  logic [31:0]            win_view [NUM_WIN];

  // Visible window value: masked address, prefetch copy, low bits zero.
  always_comb begin
    for (int w = 0; w < NUM_WIN; w++) begin
      win_view[w] = {win_q[w] & win_mask_i[w][31:WIN_ADDR_LSB], // see [R17]
                     win_prefetch_i[w],                         // see [R4]
                     WIN_LOW_ZERO};                             // see [R5] see [R6]
    end
  end

  // Reads one header dword by index; unused dwords read zero.
  function automatic logic [31:0] read_dw(input logic [5:0] idx);
    read_dw = 32'h0000_0000;
    if (idx == IDX_HDR_DW) begin
      read_dw = {SELF_TEST_VAL, HDR_LAYOUT, 16'h0000};          // see [R1] see [R2]
    end else if (idx >= IDX_WIN0 && idx < IDX_WIN0 + 6'(NUM_WIN)) begin
      read_dw = win_view[3'(idx - IDX_WIN0)];
    end else if (idx == IDX_BOARD_DW) begin
      read_dw = {BOARD_DEV_ID, BOARD_MAKER_ID};                 // see [R7] see [R8]
    end else if (idx == IDX_CAP_DW) begin
      read_dw = {24'h000000, CAP_PTR_VAL};                      // see [R9]
    end else if (idx == IDX_IRQ_DW) begin
      read_dw = {intv_q, burst_q, IRQ_PIN_VAL, line_q};         // see [R11]
    end
  endfunction : read_dw

  // ==========================================================================
  // Access routing

  logic [6:0]  loc_map, mem_map;
  logic        win0_hit;
  logic [11:0] mem_off;
  logic [2:0]  acc_ok;
  logic [5:0]  acc_idx [3];
  pcr_req_t    acc_req [3];

  // Works out which access reaches which dword; later entries win on writes.
  always_comb begin
    loc_map  = mirror_index(loc_req_i.addr[11:0]);                         // see [R14]
    win0_hit = ((mem_req_i.addr[31:WIN_ADDR_LSB] ^ win_view[0][31:WIN_ADDR_LSB])
                & win_mask_i[0][31:WIN_ADDR_LSB]) == '0;                   // see [R15]
    mem_off  = mem_req_i.addr[11:0] & ~win_mask_i[0][11:0];
    mem_map  = mirror_index(mem_off);
    acc_req[0] = loc_req_i;
    acc_req[1] = mem_req_i;
    acc_req[2] = cfg_req_i;
    acc_ok[0]  = loc_req_i.valid & loc_map[6] & bus_clk_running_i;         // see [R16]
    acc_ok[1]  = mem_req_i.valid & win0_hit & mem_map[6] & bus_clk_running_i;
    acc_ok[2]  = cfg_req_i.valid;
    acc_idx[0] = loc_map[5:0];
    acc_idx[1] = mem_map[5:0];
    acc_idx[2] = cfg_req_i.addr[7:2];
  end

  // Next register values from the writes of this cycle.
  always_comb begin
    logic [31:0] lm;
    logic [5:0]  ix;
    lm      = 32'h0000_0000;
    ix      = 6'h00;
    win_d   = win_q;
    line_d  = line_q;
    burst_d = burst_q;
    intv_d  = intv_q;
    for (int s = 0; s < 3; s++) begin
      if (acc_ok[s] && acc_req[s].write) begin
        lm = lane_mask(acc_req[s].be);
        ix = acc_idx[s];
        if (ix >= IDX_WIN0 && ix < IDX_WIN0 + 6'(NUM_WIN)) begin
          win_d[3'(ix - IDX_WIN0)] =
            (win_d[3'(ix - IDX_WIN0)] & ~(lm[31:4] & win_mask_i[3'(ix - IDX_WIN0)][31:4]))
            | (acc_req[s].wdata[31:4] & lm[31:4]
               & win_mask_i[3'(ix - IDX_WIN0)][31:4]);             // see [R3]
        end else if (ix == IDX_IRQ_DW) begin
          if (acc_req[s].be[0]) begin
            line_d = acc_req[s].wdata[7:0];                        // see [R10]
          end
          if (acc_req[s].be[2]) begin
            burst_d = acc_req[s].wdata[23:16];                     // see [R12]
          end
          if (acc_req[s].be[3]) begin
            intv_d = acc_req[s].wdata[31:24];                      // see [R13]
          end
        end
      end
    end
  end

  // Registers the header state.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int w = 0; w < NUM_WIN; w++) begin
        win_q[w] <= '0;
      end
      line_q  <= LINE_RESET;                                       // see [R10]
      burst_q <= HINT_RESET;                                       // see [R12]
      intv_q  <= HINT_RESET;                                       // see [R13]
    end else begin
      win_q   <= win_d;
      line_q  <= line_d;
      burst_q <= burst_d;
      intv_q  <= intv_d;
    end
  end

  // ==========================================================================
  // Answers

  logic [31:0] cfg_rdata_d, loc_rdata_d, mem_rdata_d;
  logic        cfg_ack_d, loc_ack_d, mem_ack_d;

  // Every local access is answered; refused ones read zero. Window misses stay silent.
  always_comb begin
    cfg_ack_d   = cfg_req_i.valid;
    loc_ack_d   = loc_req_i.valid;
    mem_ack_d   = mem_req_i.valid & win0_hit;
    cfg_rdata_d = read_dw(acc_idx[2]);
    loc_rdata_d = acc_ok[0] ? read_dw(acc_idx[0]) : 32'h0000_0000;  // see [R16]
    mem_rdata_d = acc_ok[1] ? read_dw(acc_idx[1]) : 32'h0000_0000;  // see [R15]
  end

  // Registers the answers.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_rdata_o <= 32'h0000_0000;
      loc_rdata_o <= 32'h0000_0000;
      mem_rdata_o <= 32'h0000_0000;
      cfg_ack_o   <= 1'b0;
      loc_ack_o   <= 1'b0;
      mem_ack_o   <= 1'b0;
    end else begin
      cfg_rdata_o <= cfg_rdata_d;
      loc_rdata_o <= loc_rdata_d;
      mem_rdata_o <= mem_rdata_d;
      cfg_ack_o   <= cfg_ack_d;
      loc_ack_o   <= loc_ack_d;
      mem_ack_o   <= mem_ack_d;
    end
  end

  // ==========================================================================
  // Checks

  AST_HDR_DW: assert property (@(posedge clk_i) disable iff (reset_i) // see [R1] see [R2]
    cfg_req_i.valid && cfg_req_i.addr[7:2] == IDX_HDR_DW |=>
      cfg_ack_o && cfg_rdata_o[31:16] == {SELF_TEST_VAL, HDR_LAYOUT})
    else $error("Header dword read back wrong.");

  AST_WIN_LOW: assert property (@(posedge clk_i) disable iff (reset_i) // see [R5] see [R6]
    cfg_req_i.valid && cfg_req_i.addr[7:2] == IDX_WIN0 |=>
      cfg_rdata_o[2:0] == 3'h0 && cfg_rdata_o[3] == $past(win_prefetch_i[0]))
    else $error("Window low bits wrong.");

  AST_WIN_MASK: assert property (@(posedge clk_i) disable iff (reset_i) // see [R3]
    cfg_req_i.valid && cfg_req_i.write && cfg_req_i.addr[7:2] == IDX_WIN0
      && cfg_req_i.be == 4'hf && !loc_req_i.valid && !mem_req_i.valid |=>
      win_q[0] == (($past(win_q[0]) & ~$past(win_mask_i[0][31:4]))
                   | ($past(cfg_req_i.wdata[31:4]) & $past(win_mask_i[0][31:4]))))
    else $error("Window write ignored the mask.");

  AST_WIN_RO_ZERO: assert property (@(posedge clk_i) disable iff (reset_i) // see [R17]
    cfg_req_i.valid && cfg_req_i.addr[7:2] == IDX_WIN0 + 6'h1 |=>
      (cfg_rdata_o[31:4] & ~$past(win_mask_i[1][31:4])) == '0)
    else $error("Read-only window bits not zero.");

  AST_BOARD: assert property (@(posedge clk_i) disable iff (reset_i) // see [R7] see [R8]
    cfg_req_i.valid && cfg_req_i.addr[7:2] == IDX_BOARD_DW |=>
      cfg_rdata_o == {BOARD_DEV_ID, BOARD_MAKER_ID})
    else $error("Board idents wrong.");

  AST_CAP: assert property (@(posedge clk_i) disable iff (reset_i) // see [R9]
    cfg_req_i.valid && cfg_req_i.addr[7:2] == IDX_CAP_DW |=> cfg_rdata_o == 32'h0000_0040)
    else $error("Capability pointer wrong.");

  AST_IRQ_LINE: assert property (@(posedge clk_i) disable iff (reset_i) // see [R10]
    cfg_req_i.valid && cfg_req_i.write && cfg_req_i.addr[7:2] == IDX_IRQ_DW
      && cfg_req_i.be[0] |=> line_q == $past(cfg_req_i.wdata[7:0]))
    else $error("Irq line write not stored.");

  AST_IRQ_PIN: assert property (@(posedge clk_i) disable iff (reset_i) // see [R11]
    cfg_req_i.valid && !cfg_req_i.write && cfg_req_i.addr[7:2] == IDX_IRQ_DW |=>
      cfg_rdata_o[15:8] == IRQ_PIN_VAL)
    else $error("Irq pin byte wrong.");

  AST_BURST_WRITE: assert property (@(posedge clk_i) disable iff (reset_i) // see [R12]
    cfg_req_i.valid && cfg_req_i.write && cfg_req_i.addr[7:2] == IDX_IRQ_DW
      && cfg_req_i.be[2] |=> burst_q == $past(cfg_req_i.wdata[23:16]))
    else $error("Burst length hint write not stored.");

  AST_INTV_WRITE: assert property (@(posedge clk_i) disable iff (reset_i) // see [R13]
    cfg_req_i.valid && cfg_req_i.write && cfg_req_i.addr[7:2] == IDX_IRQ_DW
      && cfg_req_i.be[3] |=> intv_q == $past(cfg_req_i.wdata[31:24]))
    else $error("Access interval hint write not stored.");

  AST_HINT_RESET: assert property (@(posedge clk_i) // see [R12] see [R13]
    $fell(reset_i) |-> burst_q == 8'h00 && intv_q == 8'h00 && line_q == 8'h00)
    else $error("Hints not zero after reset.");

  AST_STOPPED: assert property (@(posedge clk_i) disable iff (reset_i) // see [R16]
    loc_req_i.valid && !bus_clk_running_i |=> loc_ack_o && loc_rdata_o == 32'h0)
    else $error("Mirror served while bus clock stopped.");

  AST_MIRROR: assert property (@(posedge clk_i) disable iff (reset_i) // see [R14]
    loc_req_i.valid && bus_clk_running_i && loc_req_i.addr[11:0] == MIR_CAP |=>
      loc_rdata_o == 32'h0000_0040)
    else $error("Mirror of capability pointer wrong.");

  AST_WIN0_MISS: assert property (@(posedge clk_i) disable iff (reset_i) // see [R15]
    mem_req_i.valid && !win0_hit |=> !mem_ack_o && mem_rdata_o == 32'h0)
    else $error("Access outside window 0 answered.");

  // Answers on the local and memory paths and refused writes on the local path.
  AST_LOC_ACK: assert property (@(posedge clk_i) disable iff (reset_i) // see [R14]
    loc_req_i.valid |=> loc_ack_o)
    else $error("Local access not acknowledged.");

  AST_LOC_UNMAPPED: assert property (@(posedge clk_i) disable iff (reset_i) // see [R14]
    loc_req_i.valid && !loc_map[6] |=> loc_rdata_o == 32'h0000_0000)
    else $error("Unmapped local offset read nonzero.");

  AST_MEM_HIT: assert property (@(posedge clk_i) disable iff (reset_i) // see [R15]
    mem_req_i.valid && win0_hit |=> mem_ack_o)
    else $error("Access inside window 0 not answered.");

  AST_STOPPED_WRITE: assert property (@(posedge clk_i) disable iff (reset_i) // see [R16]
    loc_req_i.valid && loc_req_i.write && !bus_clk_running_i && !cfg_req_i.valid |=>
      line_q == $past(line_q) && burst_q == $past(burst_q) && intv_q == $past(intv_q))
    else $error("Local write landed while bus clock stopped.");

endmodule : pcr_config_header

/* File: shared/pcr_pkg.sv */
// ============================================================================
// Shared constants and carriers for the configuration header bank.
package pcr_pkg;

  // Number of memory windows and their field layout.
  localparam int          NUM_WIN       = 6;
  localparam int          WIN_ADDR_LSB  = 4;
  localparam int          WIN_PREF_BIT  = 3;
  localparam logic [2:0]  WIN_LOW_ZERO  = 3'h0;   // Type bits and space kind bit.

  // Dword indices of the header as seen by configuration cycles.
  localparam logic [5:0]  IDX_HDR_DW    = 6'h03;  // Self-test and header layout.
  localparam logic [5:0]  IDX_WIN0      = 6'h04;  // First window base, five follow.
  localparam logic [5:0]  IDX_BOARD_DW  = 6'h0b;  // Board maker and device idents.
  localparam logic [5:0]  IDX_CAP_DW    = 6'h0d;  // Capability list pointer.
  localparam logic [5:0]  IDX_IRQ_DW    = 6'h0f;  // Irq line, pin, hints.

  // Byte offsets of the local mirror registers.
  localparam logic [11:0] MIR_HDR       = 12'h10c;
  localparam logic [11:0] MIR_BOARD     = 12'h12c;
  localparam logic [11:0] MIR_CAP       = 12'h134;
  localparam logic [11:0] MIR_IRQ       = 12'h13c;
  localparam logic [11:0] MIR_WIN0      = 12'h1e0;
  localparam logic [11:0] MIR_WIN5      = 12'h1f4;
  localparam logic [11:0] MIR_CFG_BASE  = 12'h100;  // Mirror offset minus header offset.

  // Fixed and reset values.
  localparam logic [7:0]  SELF_TEST_VAL = 8'h00;
  localparam logic [7:0]  CAP_PTR_VAL   = 8'h40;
  localparam logic [7:0]  IRQ_PIN_VAL   = 8'h01;
  localparam logic [7:0]  HINT_RESET    = 8'h00;
  localparam logic [7:0]  LINE_RESET    = 8'h00;

  // One access request: valid, direction, byte address, lanes and data.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcr_req_t;

endpackage : pcr_pkg

/* File: verification/pcr_host_model.sv */
`timescale 1ns/100ps
// ============================================================================
// Host model: issues one configuration or memory cycle per call.
module pcr_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] cfg_rdata_i,
  input  wire logic        cfg_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  input  wire logic        mem_ack_i,
  output pcr_pkg::pcr_req_t cfg_o,
  output pcr_pkg::pcr_req_t mem_o
);
  import pcr_pkg::*;

  // Both request lines start idle.
  initial begin
    cfg_o = '0;
    mem_o = '0;
  end

  // Hold the request for the taking edge, then release to inverted lines.
  task automatic cyc(input logic mem, input logic wr, input logic [31:0] a,
                     input logic [3:0] be, input logic [31:0] d,
                     output logic [31:0] q, output logic ack);
    pcr_req_t r;
    r = '{valid: 1'b1, write: wr, addr: a, be: be, wdata: d};
    @(posedge clk_i);
    if (mem)
      mem_o <= r;    // Mirror access only through window 0
    else
      cfg_o <= r;    // Base and irq line setup by host
    @(posedge clk_i);
    if (mem)
      mem_o <= ~r;
    else
      cfg_o <= ~r;
    #1;
    q   = mem ? mem_rdata_i : cfg_rdata_i;
    ack = mem ? mem_ack_i : cfg_ack_i;
  endtask : cyc
endmodule : pcr_host_model

/* File: verification/test_pci_config_header_regs.sv */
`timescale 1ns/100ps
// ============================================================================
// Self-checking bench for the configuration header bank.
module test_pci_config_header_regs;
  import pcr_pkg::*;
  localparam logic [7:0]  LAYOUT   = 8'h5a;
  localparam logic [15:0] DEV_ID   = 16'h1234;  // Arbitrary value.
  localparam logic [15:0] MAKER_ID = 16'h5678;  // Arbitrary value.
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  pcr_req_t    cfg_req, mem_req, loc_req;
  logic [31:0] win_mask [NUM_WIN];
  logic [5:0]  win_pref = 6'h2a;
  logic        bus_run  = 1'b1;
  logic [31:0] cfg_rdata, loc_rdata, mem_rdata, a, e;
  logic        cfg_ack, loc_ack, mem_ack;
  int          error_cnt = 0;
  int          checked   = 0;
  int          cycles    = 0;

  pcr_config_header #(.HDR_LAYOUT(LAYOUT), .BOARD_DEV_ID(DEV_ID), .BOARD_MAKER_ID(MAKER_ID))
    pcr_config_header_i (.clk_i(clk), .reset_i(rst), .cfg_req_i(cfg_req),
    .loc_req_i(loc_req), .mem_req_i(mem_req), .win_mask_i(win_mask),
    .win_prefetch_i(win_pref), .bus_clk_running_i(bus_run), .cfg_rdata_o(cfg_rdata),
    .cfg_ack_o(cfg_ack), .loc_rdata_o(loc_rdata), .loc_ack_o(loc_ack),
    .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack));

  pcr_host_model pcr_host_model_i (.clk_i(clk), .cfg_rdata_i(cfg_rdata),
    .cfg_ack_i(cfg_ack), .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack),
    .cfg_o(cfg_req), .mem_o(mem_req));

  // Clock and cycle ceiling.
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Compare, report and verdict.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // Host cycle with expected ack and, on reads, expected data.
  task automatic hx(input logic mem, input logic wr, input logic [31:0] ad,
                    input logic [3:0] be, input logic [31:0] d, input logic [31:0] ex,
                    input logic ek);
    logic [31:0] q;
    logic        k;
    pcr_host_model_i.cyc(mem, wr, ad, be, d, q, k);
    check({31'h0, k}, {31'h0, ek}, "host ack");
    if (!wr)
      check(q, ex, "host read");
  endtask : hx

  // Local processor cycle; it is always acknowledged.
  task automatic lx(input logic wr, input logic [31:0] ad, input logic [3:0] be,
                    input logic [31:0] d, input logic [31:0] ex);
    pcr_req_t r;
    r = '{valid: 1'b1, write: wr, addr: ad, be: be, wdata: d};
    @(posedge clk);
    loc_req <= r;
    @(posedge clk);
    loc_req <= ~r;
    #1;
    check({31'h0, loc_ack}, 32'h1, "local ack");
    if (!wr)
      check(loc_rdata, ex, "local read");
  endtask : lx

  // ==========================================================================
  // Main sequence.
  initial begin
    loc_req = '0;
    for (int n = 0; n < NUM_WIN; n++)
      win_mask[n] = 32'hffff_ffff << (4 * n);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    hx(0, 1, 32'h0c, 4'hf, '1, 0, 1);
    hx(0, 0, 32'h0c, 4'hf, 0, {8'h00, LAYOUT, 16'h0}, 1);
    hx(0, 0, 32'h2c, 4'hf, 0, {DEV_ID, MAKER_ID}, 1);
    hx(0, 1, 32'h34, 4'hf, '1, 0, 1);
    hx(0, 0, 32'h34, 4'hf, 0, 32'h40, 1);
    hx(0, 0, 32'h3c, 4'hf, 0, 32'h0000_0100, 1);
    hx(0, 1, 32'h3c, 4'hf, 32'h3322_1144, 0, 1);
    hx(0, 1, 32'h3c, 4'h1, '1, 0, 1);
    hx(0, 0, 32'h3c, 4'hf, 0, 32'h3322_01ff, 1);
    $display("test fixed_fields done");
    for (int n = 0; n < NUM_WIN; n++) begin
      a = 32'h10 + 32'(4 * n);
      e = (win_mask[n] & 32'hffff_fff0) | (32'(win_pref[n]) << 3);
      hx(0, 0, a, 4'hf, 0, 32'(win_pref[n]) << 3, 1);
      hx(0, 1, a, 4'hf, '1, 0, 1);
      hx(0, 0, a, 4'hf, 0, e, 1);
      lx(0, 32'h1e0 + 32'(4 * n), 4'hf, 0, e);
    end
    lx(1, 32'h1e4, 4'hf, 32'h0000_0000, 0);
    hx(0, 0, 32'h14, 4'hf, 0, 32'(win_pref[1]) << 3, 1);
    $display("test windows done");
    lx(0, 32'h134, 4'hf, 0, 32'h40);
    lx(0, 32'h10c, 4'hf, 0, {8'h00, LAYOUT, 16'h0});
    lx(0, 32'h12c, 4'hf, 0, {DEV_ID, MAKER_ID});
    lx(1, 32'h13c, 4'hf, 32'h0000_0077, 0);
    hx(0, 0, 32'h3c, 4'hf, 0, 32'h0000_0177, 1);
    lx(0, 32'h200, 4'hf, 0, 0);
    @(posedge clk);
    bus_run <= 1'b0;
    lx(0, 32'h134, 4'hf, 0, 0);
    lx(1, 32'h13c, 4'hf, '1, 0);
    @(posedge clk);
    bus_run <= 1'b1;
    lx(0, 32'h13c, 4'hf, 0, 32'h0000_0177);
    $display("test local done");
    @(posedge clk);
    win_mask[0] <= 32'hffff_f000;
    hx(0, 1, 32'h10, 4'hf, 32'ha000_0000, 0, 1);
    hx(1, 0, 32'ha000_013c, 4'hf, 0, 32'h0000_0177, 1);
    hx(1, 1, 32'ha000_013c, 4'h1, 32'h0000_0099, 0, 1);
    hx(0, 0, 32'h3c, 4'hf, 0, 32'h0000_0199, 1);
    @(posedge clk);
    bus_run <= 1'b0;
    hx(1, 0, 32'ha000_013c, 4'hf, 0, 0, 1);
    @(posedge clk);
    bus_run <= 1'b1;
    hx(1, 0, 32'hb000_013c, 4'hf, 0, 0, 0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    hx(0, 0, 32'h3c, 4'hf, 0, 32'h0000_0100, 1);
    $display("test host_window done");
    give_verdict();
  end
endmodule : test_pci_config_header_regs
